// File: pkg/retrans_pkg.sv
// Constants, types and register map of the retransmission supervisor.
// Assumes a 25 MHz core_clk and an APB master with 32-bit data.
// Notes on behaviour
// - Count sequence changes while awaiting expected sequence
// - Wrap limit zero disables wrap counter
// - Wrap flag holds until clear pulsed
// - Watchdog limit forms upper terminal count bits
// - Watchdog limit zero disables watchdog
// - Watchdog advances once per received word
// - Watchdog flag holds until clear pulsed
// - Packet bus clock runs bus and control
// - Protocol clock kept apart from bus clock
// - Per-lane receive clocks, common when buffered
// - One transmit lane clock drives transmit lanes
// - Independent receive and transmit resets
// - Any reset order works correctly
// - Global reset plus per-path datapath resets
// - Synchronous mode: helpers use lane-zero transmit clock
// - Asynchronous mode: receive helper uses receive clock
// - Timers start on CRC24 retransmission request
package retrans_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned SEQ_W = 8;
  localparam int unsigned WRAP_W = 8;
  localparam int unsigned WDOG_LIMIT_W = 12;
  localparam int unsigned WDOG_W = 32;
  localparam int unsigned WDOG_LOW_BITS = 20;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] LIMIT_OFFSET = 8'h04;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h08;
  localparam logic [ADDR_W-1:0] WRAP_COUNT_OFFSET = 8'h0c;
  localparam logic [ADDR_W-1:0] WDOG_COUNT_OFFSET = 8'h10;

  // Field positions
  localparam int unsigned WRAP_LIMIT_LSB = 0;
  localparam int unsigned WDOG_LIMIT_LSB = 16;
  localparam int unsigned CTRL_FIELD_W = 6;

  // Control register, top bit first (clear request is bit 0)
  typedef struct packed {
    logic rx_buffer_enable;
    logic clock_mode_async;
    logic global_reset;
    logic tx_datapath_reset;
    logic rx_datapath_reset;
    logic retransmission_logic_clear;
  } ctrl_s;

  localparam ctrl_s CTRL_RESET = 6'h00;
  localparam logic [WRAP_W-1:0] WRAP_LIMIT_RESET = 8'h00;
  localparam logic [WDOG_LIMIT_W-1:0] WDOG_LIMIT_RESET = 12'h000;

  // One sampled link word
  typedef struct packed {
    logic word_valid;
    logic crc_error;
    logic expected_seen;
    logic [SEQ_W-1:0] seq_num;
  } link_s;

  typedef enum logic [0:0] {
    SUP_IDLE = 1'b0,
    SUP_WAIT = 1'b1
  } sup_state_e;

endpackage

// File: verilog/retrans_supervisor.sv
// Retransmission supervision timers and reset/clock-mode control.
// Assumes an APB master on core_clk and a slow link clock pin that
// core_clk oversamples; link fields are stable around its rising edge.
`timescale 1ns/10ps
module retrans_supervisor
  import retrans_pkg::*;
#(
  parameter int unsigned WDOG_SHIFT = WDOG_LOW_BITS
) (
  input wire logic core_clk, // Block clock, 25 MHz
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic clk_en, // Freezes all state when low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [ADDR_W-1:0] paddr, // APB byte address
  input wire logic [DATA_W-1:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [DATA_W-1:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic link_clk, // Link word clock pin
  input wire link_s link_word, // Link word fields pin group
  output logic wrap_timeout_flag, // Sticky wrap-around error
  output logic watchdog_timeout_flag, // Sticky watchdog error
  output logic rx_path_reset, // Receive datapath reset, high active
  output logic tx_path_reset, // Transmit datapath reset, high active
  output logic rx_helper_on_rx_clk, // Receive helper on receive clock
  output logic lane_clock_shared // Receive lane clocks common
);

  // Register state
  ctrl_s ctrl;
  logic [WRAP_W-1:0] wrap_limit_setting;
  logic [WDOG_LIMIT_W-1:0] watchdog_limit_setting;

  // Supervisor state
  sup_state_e state;
  logic [WRAP_W-1:0] wrap_count;
  logic [WDOG_W-1:0] wdog_count;
  logic [SEQ_W-1:0] last_seq;
  logic clear_prev;

  // Link sampling
  link_s link_meta;
  link_s link_sync;
  logic clk_meta;
  logic clk_sync;
  logic clk_last;
  logic link_edge;
  logic word_stb;
  logic clear_release;
  logic seq_changed;
  logic [WDOG_W-1:0] wdog_terminal;
  logic wrap_hit;
  logic wdog_hit;
  logic apb_write;
  logic apb_read;
  logic [DATA_W-1:0] next_prdata;
  logic addr_ok;
  logic [DATA_W-1:0] limit_word;
  logic [DATA_W-1:0] limit_merged;

  // Byte-lane merge used by every writable field
  function automatic logic [DATA_W-1:0] merge_bytes(
    input logic [DATA_W-1:0] old_val,
    input logic [DATA_W-1:0] new_val,
    input logic [3:0] strb
  );
    logic [DATA_W-1:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Address decode, used by write decode and error answer
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return (a == CTRL_OFFSET) || (a == LIMIT_OFFSET) ||
      (a == STATUS_OFFSET) || (a == WRAP_COUNT_OFFSET) ||
      (a == WDOG_COUNT_OFFSET);
  endfunction

  // Zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign addr_ok = mapped(paddr);
  assign pslverr = psel & penable & ~addr_ok;
  assign apb_write = psel & penable & pwrite & addr_ok;
  assign apb_read = psel & ~penable & ~pwrite;

  // Limit fields as software sees them, merged per byte lane so a
  // partial write keeps the other field intact
  assign limit_word = (DATA_W'(wrap_limit_setting) << WRAP_LIMIT_LSB) |
    (DATA_W'(watchdog_limit_setting) << WDOG_LIMIT_LSB);
  assign limit_merged = merge_bytes(limit_word, pwdata, pstrb);

  // Link clock and fields pass two flops before any logic reads them
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      clk_meta <= 1'b0;
      clk_sync <= 1'b0;
      clk_last <= 1'b0;
      link_meta <= '0;
      link_sync <= '0;
    end else if (clk_en) begin
      clk_meta <= link_clk;
      clk_sync <= clk_meta;
      clk_last <= clk_sync;
      link_meta <= link_word;
      link_sync <= link_meta;
    end
  end

  // Rising edge of the link clock marks one word slot
  assign link_edge = clk_sync & ~clk_last;
  assign word_stb = link_edge & link_sync.word_valid;
  assign seq_changed = word_stb & (link_sync.seq_num != last_seq);

  // Clear acts on its falling edge; while high it holds counters at zero and the state idle
  assign clear_release = clear_prev & ~ctrl.retransmission_logic_clear;

  // Terminal count: limit supplies the top bits of the 32-bit value
  assign wdog_terminal = WDOG_W'(watchdog_limit_setting) << WDOG_SHIFT;
  assign wrap_hit = (wrap_limit_setting != WRAP_LIMIT_RESET) &&
    (state == SUP_WAIT) && seq_changed &&
    (wrap_count + WRAP_W'(1) == wrap_limit_setting);
  assign wdog_hit = (watchdog_limit_setting != WDOG_LIMIT_RESET) &&
    (state == SUP_WAIT) && word_stb &&
    (wdog_count + WDOG_W'(1) == wdog_terminal);

  // Control register; software writes steer resets and clock modes
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ctrl <= CTRL_RESET;
    end else if (clk_en && apb_write && paddr == CTRL_OFFSET) begin
      ctrl <= ctrl_s'(CTRL_FIELD_W'(merge_bytes(
        DATA_W'(ctrl), pwdata, pstrb)));
    end
  end

  // Limit register; values meant for reset-time change only
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wrap_limit_setting <= WRAP_LIMIT_RESET;
      watchdog_limit_setting <= WDOG_LIMIT_RESET;
    end else if (clk_en && apb_write && paddr == LIMIT_OFFSET) begin
      wrap_limit_setting <= limit_merged[WRAP_LIMIT_LSB +: WRAP_W];
      watchdog_limit_setting <=
        limit_merged[WDOG_LIMIT_LSB +: WDOG_LIMIT_W];
    end
  end

  // Remember the clear level to find its release
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      clear_prev <= 1'b0;
    end else if (clk_en) begin
      clear_prev <= ctrl.retransmission_logic_clear;
    end
  end

  // Wait state: entered on a CRC24-driven request, left on a match
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state <= SUP_IDLE;
    end else if (clk_en) begin
      if (ctrl.retransmission_logic_clear || rx_path_reset) begin
        state <= SUP_IDLE;
      end else begin
        unique case (state)
          SUP_IDLE: begin
            if (link_edge && link_sync.crc_error) begin
              state <= SUP_WAIT;
            end
          end
          SUP_WAIT: begin
            if (link_edge && link_sync.expected_seen) begin
              state <= SUP_IDLE;
            end
          end
        endcase
      end
    end
  end

  // Last primary sequence seen, tracked on every received word
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      last_seq <= '0;
    end else if (clk_en && word_stb) begin
      last_seq <= link_sync.seq_num;
    end
  end

  // Wrap-around counter counts sequence changes while waiting
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wrap_count <= '0;
    end else if (clk_en) begin
      if (state != SUP_WAIT || ctrl.retransmission_logic_clear) begin
        wrap_count <= '0;
      end else if (seq_changed && !wrap_timeout_flag &&
                   wrap_limit_setting != WRAP_LIMIT_RESET) begin
        wrap_count <= wrap_count + WRAP_W'(1);
      end
    end
  end

  // Watchdog counts incoming words, not clock cycles
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wdog_count <= '0;
    end else if (clk_en) begin
      if (state != SUP_WAIT || ctrl.retransmission_logic_clear) begin
        wdog_count <= '0;
      end else if (word_stb && !watchdog_timeout_flag &&
                   watchdog_limit_setting != WDOG_LIMIT_RESET) begin
        wdog_count <= wdog_count + WDOG_W'(1);
      end
    end
  end

  // Sticky wrap flag; a hit in the release cycle still sets it
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wrap_timeout_flag <= 1'b0;
    end else if (clk_en) begin
      if (wrap_hit) begin
        wrap_timeout_flag <= 1'b1;
      end else if (clear_release) begin
        wrap_timeout_flag <= 1'b0;
      end
    end
  end

  // Sticky watchdog flag, same set-over-clear priority
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      watchdog_timeout_flag <= 1'b0;
    end else if (clk_en) begin
      if (wdog_hit) begin
        watchdog_timeout_flag <= 1'b1;
      end else if (clear_release) begin
        watchdog_timeout_flag <= 1'b0;
      end
    end
  end

  // Path resets: global drives both, each path also alone. Registered
  // so either order of setting or releasing bits is glitch free.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rx_path_reset <= 1'b1;
      tx_path_reset <= 1'b1;
    end else if (clk_en) begin
      rx_path_reset <= ctrl.global_reset | ctrl.rx_datapath_reset;
      tx_path_reset <= ctrl.global_reset | ctrl.tx_datapath_reset;
    end
  end

  // Helper clock choice and shared lane clock indication
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rx_helper_on_rx_clk <= 1'b0;
      lane_clock_shared <= 1'b0;
    end else if (clk_en) begin
      rx_helper_on_rx_clk <= ctrl.clock_mode_async;
      lane_clock_shared <= ctrl.rx_buffer_enable;
    end
  end

  // Read mux; status shows the block's own state
  always_comb begin
    next_prdata = '0;
    unique case (paddr)
      CTRL_OFFSET: next_prdata = DATA_W'(ctrl);
      LIMIT_OFFSET: begin
        next_prdata[WRAP_LIMIT_LSB +: WRAP_W] = wrap_limit_setting;
        next_prdata[WDOG_LIMIT_LSB +: WDOG_LIMIT_W] =
          watchdog_limit_setting;
      end
      STATUS_OFFSET: next_prdata = DATA_W'({tx_path_reset,
        rx_path_reset, state == SUP_WAIT, watchdog_timeout_flag,
        wrap_timeout_flag});
      WRAP_COUNT_OFFSET: next_prdata = DATA_W'(wrap_count);
      WDOG_COUNT_OFFSET: next_prdata = wdog_count;
      default: next_prdata = '0;
    endcase
  end

  // Read data latched in setup so it stands through the access phase
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      prdata <= '0;
    end else if (clk_en && apb_read) begin
      prdata <= next_prdata;
    end
  end

endmodule // retrans_supervisor

// File: testbench/retrans_asserts.sv
// Port checker for the retransmission supervisor, bound to the design.
// Assumes CTRL and LIMIT change only by full-word APB writes.
`timescale 1ns/10ps
module retrans_asserts
  import retrans_pkg::*;
#(
  parameter int unsigned WDOG_SHIFT = WDOG_LOW_BITS // Count shift
) (
  input wire logic core_clk, // Clock
  input wire logic reset_n, // Reset
  input wire logic clk_en, // Enable
  input wire logic psel, // Select
  input wire logic penable, // Access
  input wire logic pwrite, // Direction
  input wire logic [ADDR_W-1:0] paddr, // Address
  input wire logic [DATA_W-1:0] pwdata, // Write data
  input wire logic link_clk, // Link pin
  input wire logic wrap_timeout_flag, // Wrap error
  input wire logic watchdog_timeout_flag, // Watchdog error
  input wire logic rx_path_reset, // Rx reset
  input wire logic tx_path_reset, // Tx reset
  input wire logic rx_helper_on_rx_clk // Helper select
);
  logic [5:0] ctl; // Shadow of CTRL
  logic wz, dz; // Limits are zero
  logic [7:0] lh; // Link pin history
  wire wr = psel && penable && pwrite && clk_en;
  wire rx_rq = ctl[1] | ctl[3];
  wire tx_rq = ctl[2] | ctl[3];

  // Settings rebuilt from writes; strobes assumed all ones
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ctl <= 6'h00;
      wz <= 1'b1;
      dz <= 1'b1;
    end else if (wr && paddr == CTRL_OFFSET) begin
      ctl <= pwdata[5:0];
    end else if (wr && paddr == LIMIT_OFFSET) begin
      wz <= pwdata[7:0] == 8'h00;
      dz <= pwdata[27:16] == 12'h000;
    end
  end

  // Eight deep so the sync and detect delay stays inside the window
  always_ff @(posedge core_clk) begin
    lh <= reset_n ? {lh[6:0], link_clk} : 8'h00;
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence rel_seen;
    !ctl[0] && ($past(ctl[0]) || $past(ctl[0], 2));
  endsequence
  sequence slot_seen;
    |(~lh[7:1] & lh[6:0]);
  endsequence

  AST_WRAP_ZERO: assert property (
    $rose(wrap_timeout_flag) |-> !$past(wz)) else $error("wrap zero");
  AST_WDOG_ZERO: assert property (
    $rose(watchdog_timeout_flag) |-> !$past(dz)) else $error("wdog zero");
  AST_WRAP_HOLD: assert property (
    $fell(wrap_timeout_flag) |-> rel_seen) else $error("wrap hold");
  AST_WDOG_HOLD: assert property (
    $fell(watchdog_timeout_flag) |-> rel_seen) else $error("wdog hold");
  AST_WRAP_SLOT: assert property (
    $rose(wrap_timeout_flag) |-> slot_seen) else $error("wrap slot");
  AST_WDOG_SLOT: assert property (
    $rose(watchdog_timeout_flag) |-> slot_seen) else $error("wdog slot");
  AST_RX_PATH: assert property (
    $past(reset_n, 2) |-> rx_path_reset == $past(rx_rq)) else $error("rx rst");
  AST_TX_PATH: assert property (
    $past(reset_n, 2) |-> tx_path_reset == $past(tx_rq)) else $error("tx rst");
  AST_HELPER: assert property (
    rx_helper_on_rx_clk == $past(ctl[4])) else $error("helper");
endmodule // retrans_asserts

bind retrans_supervisor retrans_asserts #(.WDOG_SHIFT(WDOG_SHIFT))
  retrans_asserts_i (.core_clk(core_clk), .reset_n(reset_n),
  .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .link_clk(link_clk),
  .wrap_timeout_flag(wrap_timeout_flag),
  .watchdog_timeout_flag(watchdog_timeout_flag),
  .rx_path_reset(rx_path_reset), .tx_path_reset(tx_path_reset),
  .rx_helper_on_rx_clk(rx_helper_on_rx_clk));

// File: testbench/link_partner.sv
// Far-end link sender: one word per 320 ns slot, clock idle between.
// Assumes the caller waits for each word before sending the next.
`timescale 1ns/10ps
module link_partner
  import retrans_pkg::*;
(
  output logic link_clk, // Link word clock
  output link_s link_word // Link word fields
);
  initial begin
    link_clk = 1'b0;
    link_word = '0;
  end

  // Fields settle half a slot before the edge; afterwards they turn over
  task automatic send(input logic [2:0] k, input logic [7:0] s);
    link_word <= {k, s};
    #160 link_clk <= 1'b1;
    #160 link_clk <= 1'b0;
    link_word <= ~{k, s};
  endtask
endmodule // link_partner

// File: testbench/retrans_supervisor_tb_top.sv
// Directed bench: APB register calls and link words with expectations.
// Assumes zero-wait APB and a watchdog shift of 2 for short counts.
`timescale 1ns/10ps
module retrans_supervisor_tb_top
  import retrans_pkg::*;
;
  logic core_clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic link_clk, wrap_f, wdog_f, rxr, txr, hlp, shr;
  logic [5:0] m;
  logic clk_en;
  link_s link_word;
  int fails, checks;

  retrans_supervisor #(.WDOG_SHIFT(2)) retrans_supervisor_i (
    .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_clk(link_clk), .link_word(link_word),
    .wrap_timeout_flag(wrap_f), .watchdog_timeout_flag(wdog_f),
    .rx_path_reset(rxr), .tx_path_reset(txr),
    .rx_helper_on_rx_clk(hlp), .lane_clock_shared(shr));
  link_partner link_partner_i (.link_clk(link_clk), .link_word(link_word));

  // 25 MHz clock; no reconfiguration accesses, so no port clock runs
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic check(input string n, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic finish_test();
    if (fails == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // One APB transfer; the request stands until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Link word, then time for sync and detection to finish
  task automatic word(input logic [2:0] k, input logic [7:0] s);
    link_partner_i.send(k, s);
    repeat (4) @(posedge core_clk);
  endtask

  task automatic flags(input logic [1:0] e);
    check("flags", 32'({wrap_f, wdog_f}), 32'(e));
  endtask

  // Watchdog: the tests need about 15 us
  initial begin
    #200000;
    fails++;
    finish_test();
  end

  initial begin
    fails = 0;
    checks = 0;
    reset_n = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    apb(1'b0, CTRL_OFFSET, 32'h0);
    check("ctrl", rd, 32'h0);
    check("slverr", 32'(err), 32'h0);
    apb(1'b0, LIMIT_OFFSET, 32'h0);
    check("limit", rd, 32'h0);
    // Zero limits: a long wait raises nothing
    word(3'b100, 8'h00);
    word(3'b010, 8'h00);
    for (int i = 1; i < 9; i++) word(3'b100, 8'(i));
    flags(2'b00);
    word(3'b001, 8'h00);
    // Wrap limit 3; an invalid word in between is not a change.
    // Limits change only while the receive path is held in reset.
    apb(1'b1, CTRL_OFFSET, 32'h2);
    apb(1'b1, LIMIT_OFFSET, 32'h3);
    apb(1'b1, CTRL_OFFSET, 32'h0);
    word(3'b010, 8'h08);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    check("status", rd, 32'h4);
    word(3'b100, 8'h08);
    word(3'b100, 8'h09);
    word(3'b000, 8'h07);
    word(3'b100, 8'h0a);
    apb(1'b0, WRAP_COUNT_OFFSET, 32'h0);
    check("wrap count", rd, 32'h2);
    flags(2'b00);
    word(3'b100, 8'h0b);
    flags(2'b10);
    word(3'b001, 8'h0b);
    apb(1'b0, WRAP_COUNT_OFFSET, 32'h0);
    check("wrap clear", rd, 32'h0);
    apb(1'b1, CTRL_OFFSET, 32'h1);
    flags(2'b10);
    apb(1'b1, CTRL_OFFSET, 32'h0);
    repeat (2) @(posedge core_clk);
    flags(2'b00);
    // Watchdog limit 1, terminal count 4 words
    apb(1'b1, CTRL_OFFSET, 32'h2);
    apb(1'b1, LIMIT_OFFSET, 32'h0001_0000);
    apb(1'b1, CTRL_OFFSET, 32'h0);
    word(3'b010, 8'h0b);
    for (int i = 0; i < 3; i++) word(3'b100, 8'h0b);
    word(3'b000, 8'h0b);
    apb(1'b0, WDOG_COUNT_OFFSET, 32'h0);
    check("wdog count", rd, 32'h3);
    flags(2'b00);
    word(3'b100, 8'h0b);
    flags(2'b01);
    apb(1'b1, CTRL_OFFSET, 32'h1);
    flags(2'b01);
    apb(1'b1, CTRL_OFFSET, 32'h0);
    repeat (2) @(posedge core_clk);
    flags(2'b00);
    // Each reset and clock mode bit alone
    for (int i = 1; i < 6; i++) begin
      m = 6'h01 << i;
      apb(1'b1, CTRL_OFFSET, 32'(m));
      repeat (2) @(posedge core_clk);
      check("modes", 32'({rxr, txr, hlp, shr}),
        32'({m[1] | m[3], m[2] | m[3], m[4], m[5]}));
    end
    // A write while the enable is low is lost
    clk_en <= 1'b0;
    apb(1'b1, LIMIT_OFFSET, 32'h0000_00ff);
    clk_en <= 1'b1;
    apb(1'b0, LIMIT_OFFSET, 32'h0);
    check("frozen limit", rd, 32'h0001_0000);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped data", rd, 32'h0);
    check("unmapped error", 32'(err), 32'h1);
    finish_test();
  end
endmodule // retrans_supervisor_tb_top
